// ==== hw/expansion_port_gpio.sv ====
// Notes on behaviour
// - The port has eight pins, each independently input or output.
// - A direction bit of 0 makes its pin an input and 1 makes it an output.
// - After reset every pin is an input unless a saved setting is restored.
// - A stored output bit reaches its pin only while that pin is an output.
// - Output value bit n drives pin n.
// - A read returns the present level of all eight pins, bit n for pin n.
// - Pins set as outputs are read back at their actual level.
// - An extended read also returns the last configured direction byte.
// - An extended read also returns the last written output byte.
// - With persistence, the saved direction byte is restored at power-on.
// - With persistence, the saved output byte is restored at power-on.
module expansion_port_gpio (
   input  wire logic       clock_i,        // 250 MHz system clock
   input  wire logic       rstn_i,         // Async reset, active low
   input  wire logic       enable_i,       // Clock enable, freezes state when low
   input  wire logic       persist_en_i,   // Restore saved settings at reset release
   input  wire logic [7:0] saved_dir_i,    // Saved direction byte
   input  wire logic [7:0] saved_out_i,    // Saved output byte
   input  wire logic       cmd_valid_i,    // Command strobe
   input  wire logic [1:0] cmd_code_i,     // Command code
   input  wire logic [7:0] cmd_data_i,     // Command data byte
   output logic            cmd_ready_o,    // Command may be taken
   output logic            rsp_valid_o,    // Read answer pulse
   output logic      [7:0] pin_state_value_o,   // Pin levels
   output logic      [7:0] last_direction_mask_o, // Stored direction
   output logic      [7:0] last_output_value_o, // Stored outputs
   output logic            rsp_extended_o, // Answer came from extended read
   input  wire logic [7:0] pin_i,          // Pin levels from pads
   output logic      [7:0] pin_o,          // Pin drive values
   output logic      [7:0] pin_oe_n_o      // Output enables, low drives
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum {ST_RESTORE, ST_RUN} phase_t;

   phase_t        phase;
   logic [7:0]    pins_sync;
   port_state_if  st ();
   logic          cmd_take;

   // ------------------------------------------------------------
   // Command decoding
   // ------------------------------------------------------------
   // Shared by the update logic and the answer path so both read codes alike
   function automatic logic is_configure(input logic [1:0] code);
      is_configure = (code == gpio_pkg::CMD_CONFIGURE);
   endfunction : is_configure

   function automatic logic is_write(input logic [1:0] code);
      is_write = (code == gpio_pkg::CMD_WRITE);
   endfunction : is_write

   function automatic logic is_extended(input logic [1:0] code);
      is_extended = (code == gpio_pkg::CMD_READ_EXT);
   endfunction : is_extended

   // Both read codes fetch every answer field
   function automatic logic is_read(input logic [1:0] code);
      is_read = (code == gpio_pkg::CMD_READ) || is_extended(code);
   endfunction : is_read

   // ------------------------------------------------------------
   // Pin path
   // ------------------------------------------------------------
   pin_sync u_sync (
      .clock_i  (clock_i),
      .rstn_i   (rstn_i),
      .enable_i (enable_i),
      .async_i  (pin_i),
      .sync_o   (pins_sync)
   );

   pin_driver u_drv (
      .st          (st.user),
      .pins_sync_i (pins_sync),
      .pin_o       (pin_o),
      .pin_oe_n_o  (pin_oe_n_o)
   );

   // Commands wait one cycle after reset so the restore step wins
   assign cmd_ready_o = (phase == ST_RUN);
   assign cmd_take    = cmd_ready_o && cmd_valid_i;

   // ------------------------------------------------------------
   // Restore phase
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase <= ST_RESTORE;
      end else if (enable_i) begin
         case (phase)
            ST_RESTORE: phase <= ST_RUN;
            ST_RUN:     phase <= ST_RUN;
            default:    phase <= ST_RESTORE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Direction byte
   // ------------------------------------------------------------
   // Saved values are sampled after release, never loaded by the async reset
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st.direction_mask <= gpio_pkg::DIR_RESET;
      end else if (enable_i) begin
         if (phase == ST_RESTORE) begin
            if (persist_en_i) begin
               st.direction_mask <= saved_dir_i;
            end
         end else if (cmd_take && is_configure(cmd_code_i)) begin
            st.direction_mask <= cmd_data_i;
         end
      end
   end

   // ------------------------------------------------------------
   // Output byte
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st.output_value <= gpio_pkg::OUT_RESET;
      end else if (enable_i) begin
         if (phase == ST_RESTORE) begin
            if (persist_en_i) begin
               st.output_value <= saved_out_i;
            end
         end else if (cmd_take && is_write(cmd_code_i)) begin
            st.output_value <= cmd_data_i;
         end
      end
   end

   // ------------------------------------------------------------
   // Read answers
   // ------------------------------------------------------------
   logic read_hit;
   assign read_hit = cmd_take && is_read(cmd_code_i);

   // One block per answer field, each frozen by the clock enable
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rsp_valid_o <= 1'b0;
      end else if (enable_i) begin
         rsp_valid_o <= read_hit;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rsp_extended_o <= 1'b0;
      end else if (enable_i && read_hit) begin
         rsp_extended_o <= is_extended(cmd_code_i);
      end
   end

   // Pad levels, so driven outputs read back as they really are
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_state_value_o <= 8'h00;
      end else if (enable_i && read_hit) begin
         pin_state_value_o <= st.pins_sync;
      end
   end

   // Both stored bytes go out on a plain read too; the flag tells which was asked
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         last_direction_mask_o <= 8'h00;
      end else if (enable_i && read_hit) begin
         last_direction_mask_o <= st.direction_mask;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         last_output_value_o <= 8'h00;
      end else if (enable_i && read_hit) begin
         last_output_value_o <= st.output_value;
      end
   end

   // ------------------------------------------------------------
   // Checks on stored state and answers
   // ------------------------------------------------------------
   a_input_undriven: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (pin_oe_n_o == ~st.direction_mask)) else $error("Enable does not follow direction");

   a_out_drives_pin: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (pin_o == st.output_value)) else $error("Pin value not from output byte");

   a_config_stores: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && cmd_ready_o && cmd_valid_i && cmd_code_i == gpio_pkg::CMD_CONFIGURE
      |=> st.direction_mask == $past(cmd_data_i)) else $error("Direction not stored");

   a_write_stores: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && cmd_ready_o && cmd_valid_i && cmd_code_i == gpio_pkg::CMD_WRITE
      |=> st.output_value == $past(cmd_data_i)) else $error("Output byte not stored");

   a_read_answer: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && read_hit |=> rsp_valid_o && pin_state_value_o == $past(pins_sync))
      else $error("Read answer wrong");

   a_ext_direction: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && read_hit |=> last_direction_mask_o == $past(st.direction_mask))
      else $error("Extended direction wrong");

   a_ext_output: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && read_hit |=> last_output_value_o == $past(st.output_value))
      else $error("Extended output wrong");

   a_restore_dir: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && phase == ST_RESTORE && persist_en_i |=> st.direction_mask == $past(saved_dir_i))
      else $error("Direction not restored");

   a_restore_out: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && phase == ST_RESTORE && persist_en_i |=> st.output_value == $past(saved_out_i))
      else $error("Outputs not restored");

   a_default_input: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && phase == ST_RESTORE && !persist_en_i |=> st.direction_mask == gpio_pkg::DIR_RESET)
      else $error("Pins not inputs after reset");

   // ------------------------------------------------------------
   // Checks on restore, freeze and answer timing
   // ------------------------------------------------------------
   a_ready_after: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && phase == ST_RESTORE |=> cmd_ready_o)
      else $error("Commands still refused after restore");

   a_phase_settles: assert property (@(posedge clock_i) disable iff (!rstn_i)
      phase == ST_RUN |=> phase == ST_RUN)
      else $error("Restore step repeated without reset");

   a_restore_blocks: assert property (@(posedge clock_i) disable iff (!rstn_i)
      phase == ST_RESTORE |-> !cmd_ready_o)
      else $error("Command taken during restore");

   a_no_answer_restore: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && phase == ST_RESTORE |=> !rsp_valid_o)
      else $error("Answer during restore");

   a_restore_keeps: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && phase == ST_RESTORE && !persist_en_i |=> $stable(st.output_value))
      else $error("Output byte moved without persistence");

   // A frozen cycle leaves both stored bytes and the pin level answer as they were
   a_freeze_dir: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !enable_i |=> $stable(st.direction_mask))
      else $error("Direction moved while frozen");

   a_freeze_out: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !enable_i |=> $stable(st.output_value))
      else $error("Output byte moved while frozen");

   a_freeze_pins: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !enable_i |=> $stable(pin_state_value_o))
      else $error("Read answer moved while frozen");

   // Once past the restore step, stored bytes move only on their own command
   a_keep_dir: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && phase == ST_RUN && !(cmd_valid_i && cmd_code_i == gpio_pkg::CMD_CONFIGURE)
      |=> $stable(st.direction_mask)) else $error("Direction changed without a configure");

   a_keep_out: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && phase == ST_RUN && !(cmd_valid_i && cmd_code_i == gpio_pkg::CMD_WRITE)
      |=> $stable(st.output_value)) else $error("Output byte changed without a write");

   a_read_keeps: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && read_hit |=> $stable(st.direction_mask) && $stable(st.output_value))
      else $error("Read disturbed the port");

   a_rsp_single: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && !read_hit |=> !rsp_valid_o)
      else $error("Answer strobe without a read");

   a_ext_flag: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && read_hit |=> rsp_extended_o == ($past(cmd_code_i) == gpio_pkg::CMD_READ_EXT))
      else $error("Extended flag wrong");

   a_answer_holds: assert property (@(posedge clock_i) disable iff (!rstn_i)
      enable_i && !read_hit |=> $stable(pin_state_value_o) && $stable(last_direction_mask_o)
      && $stable(last_output_value_o)) else $error("Answer changed without a read");

   // ------------------------------------------------------------
   // Per-pin checks
   // ------------------------------------------------------------
   // Looked at bit by bit so a slip on one pin names that pin's instance
   genvar p;
   generate
      for (p = 0; p < gpio_pkg::PORT_WIDTH; p++) begin : g_pin_chk
         a_input_released: assert property (@(posedge clock_i) disable iff (!rstn_i)
            !st.direction_mask[p] |-> pin_oe_n_o[p]) else $error("Input pin is driven");

         a_output_driven: assert property (@(posedge clock_i) disable iff (!rstn_i)
            st.direction_mask[p] |-> !pin_oe_n_o[p] && pin_o[p] == st.output_value[p])
            else $error("Output pin not driven from its bit");
      end
   endgenerate

endmodule : expansion_port_gpio

// ==== hw/pin_driver.sv ====
module pin_driver (
   port_state_if.user      st,        // Stored port state
   input  wire logic [7:0] pins_sync_i, // Synchronised pin levels
   output logic      [7:0] pin_o,     // Pin drive value
   output logic      [7:0] pin_oe_n_o // Pin output enable, low drives
);

   assign st.pins_sync = pins_sync_i;

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         assign pin_o[g]      = st.output_value[g];
         assign pin_oe_n_o[g] = ~st.direction_mask[g];
      end
   endgenerate

endmodule : pin_driver

// ==== hw/pin_sync.sv ====
module pin_sync (
   input  wire logic       clock_i,   // System clock
   input  wire logic       rstn_i,    // Async reset, active low
   input  wire logic       enable_i,  // Clock enable
   input  wire logic [7:0] async_i,   // Raw pin levels
   output logic      [7:0] sync_o     // Synchronised levels
);

   logic [7:0] stage1;

   // First stage feeds only the second stage
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         stage1 <= 8'h00;
         sync_o <= 8'h00;
      end else if (enable_i) begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end

endmodule : pin_sync

// ==== include/gpio_pkg.sv ====
package gpio_pkg;

   // ------------------------------------------------------------
   // Port geometry and reset values
   // ------------------------------------------------------------
   localparam int          PORT_WIDTH        = 8;
   localparam logic [7:0]  DIR_RESET         = 8'h00;
   localparam logic [7:0]  OUT_RESET         = 8'h00;
   localparam int          SYNC_STAGES       = 2;

   // ------------------------------------------------------------
   // Command codes on the host command port
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CMD_CONFIGURE = 2'h0,
      CMD_WRITE     = 2'h1,
      CMD_READ      = 2'h2,
      CMD_READ_EXT  = 2'h3
   } cmd_t;

endpackage : gpio_pkg

// ==== include/port_state_if.sv ====
interface port_state_if;
   logic [7:0] direction_mask;
   logic [7:0] output_value;
   logic [7:0] pins_sync;

   modport owner (output direction_mask, output output_value, input pins_sync);
   modport user  (input direction_mask, input output_value, output pins_sync);
endinterface : port_state_if

// ==== testbench/expansion_port_gpio_tb.sv ====
module expansion_port_gpio_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk = 1'b0, rstn = 1'b0, en = 1'b1, pers = 1'b0, vld = 1'b0;
   logic [1:0] code = 2'h0;
   logic [7:0] data = 8'h00, sdir = 8'hC3, sout = 8'h81, ext = 8'h0F;
   logic       rdy, rsp, rext;
   logic [7:0] pst, ldir, lout, po, poe, lvl;
   int         n_fail = 0, comparisons = 0;
   always #2 clk = ~clk;
   expansion_port_gpio uut (.clock_i(clk), .rstn_i(rstn), .enable_i(en), .persist_en_i(pers),
      .saved_dir_i(sdir), .saved_out_i(sout), .cmd_valid_i(vld), .cmd_code_i(code),
      .cmd_data_i(data), .cmd_ready_o(rdy), .rsp_valid_o(rsp), .pin_state_value_o(pst),
      .last_direction_mask_o(ldir), .last_output_value_o(lout), .rsp_extended_o(rext),
      .pin_i(lvl), .pin_o(po), .pin_oe_n_o(poe));
   port_circuit_model far (.pin_o_i(po), .pin_oe_n_i(poe), .ext_i(ext), .level_o(lvl));
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // A free edge first, so back-to-back calls never drop and raise vld at once
   task automatic cmd(input logic [1:0] c, input logic [7:0] d);
      @(posedge clk);
      #1;
      vld = 1'b1;
      code = c;
      data = d;
      @(posedge clk);
      #1 vld = 1'b0;
   endtask : cmd
   // The answer strobe stands for the one cycle after the taking edge
   task automatic rd(input logic [1:0] c);
      cmd(c, 8'h00);
      chk({7'h00, rsp}, 8'h01);
   endtask : rd
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset;
      chk(poe, 8'hFF);
      rd(2'h3);
      chk(ldir, 8'h00);
   endtask : t_reset
   task automatic t_rw;
      cmd(2'h0, 8'hA5);
      cmd(2'h1, 8'h3C);
      repeat (4) @(posedge clk);
      #1;
      chk(poe, 8'h5A);
      chk(po, 8'h3C);
      chk(lvl, 8'h2E);
      rd(2'h3);
      chk(pst, 8'h2E);
      chk(ldir, 8'hA5);
      chk(lout, 8'h3C);
      chk({7'h00, rext}, 8'h01);
      rd(2'h2);
      chk({7'h00, rext}, 8'h00);
      // Input pins follow the outside load, driven pins keep their own level
      ext = 8'hF0;
      repeat (2) @(posedge clk);
      rd(2'h2);
      chk(pst, 8'h74);
   endtask : t_rw
   // Commands with the clock enable low must leave the port as it was
   task automatic t_freeze;
      en = 1'b0;
      cmd(2'h0, 8'hFF);
      en = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(poe, 8'h5A);
   endtask : t_freeze
   // A configure offered in the restore cycle must not beat the saved byte
   task automatic t_persist;
      pers = 1'b1;
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      vld = 1'b1;
      code = 2'h0;
      data = 8'hFF;
      chk({7'h00, rdy}, 8'h00);
      @(posedge clk);
      #1;
      vld = 1'b0;
      chk({7'h00, rdy}, 8'h01);
      repeat (2) @(posedge clk);
      #1;
      chk(poe, 8'h3C);
      chk(po, 8'h81);
      rd(2'h3);
      chk(ldir, 8'hC3);
      chk(lout, 8'h81);
   endtask : t_persist
   initial begin
      repeat (16) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      t_reset();
      t_rw();
      t_freeze();
      t_persist();
      tally_and_finish();
   end
   initial begin
      #20000;
      n_fail++;
      tally_and_finish();
   end
endmodule : expansion_port_gpio_tb

// ==== testbench/port_circuit_model.sv ====
module port_circuit_model (
   input  wire logic [7:0] pin_o_i,    // Drive values from the port
   input  wire logic [7:0] pin_oe_n_i, // Output enables, low drives
   input  wire logic [7:0] ext_i,      // Levels set by outside circuitry
   output logic      [7:0] level_o     // Resolved pad levels
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------
   // Pad resolution
   // ---------------------------------------------
   // A driven pin overrides the outside load; a released pin follows it
   assign level_o = (~pin_oe_n_i & pin_o_i) | (pin_oe_n_i & ext_i);
endmodule : port_circuit_model
